// [verilog/ewmon_pkg.sv]
// Purpose: shared constants and types of the external watchdog monitor
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: offsets and bit positions are local choices
package ewmon_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMP_LOW = 8'h04;
  localparam logic [7:0] ADDR_CMP_HIGH = 8'h08;
  localparam logic [7:0] ADDR_PRESCALE = 8'h0C;
  localparam logic [7:0] ADDR_REFRESH = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_COUNT = 8'h18;

  // ctrl fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_INEN_BIT = 1;
  localparam int CTRL_POL_BIT = 2;
  localparam int CTRL_IRQ_BIT = 3;
  // status fields
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_EVT_BIT = 1;

  // refresh needs this key in the low byte
  localparam logic [7:0] REFRESH_KEY = 8'hB4;

  // reset values
  localparam logic [7:0] RST_CMP_LOW = 8'h00;
  localparam logic [7:0] RST_CMP_HIGH = 8'hFE;
  localparam logic [7:0] RST_PRESCALE = 8'h00;

  // write-once slot indices
  localparam int SLOT_CTRL = 0;
  localparam int SLOT_LOW = 1;
  localparam int SLOT_HIGH = 2;
  localparam int SLOT_PRE = 3;
  localparam int NUM_SLOTS = 4;

  typedef struct packed {
    logic enable;
    logic input_enable;
    logic input_polarity_select;
    logic [7:0] window_low_bound;
    logic [7:0] window_high_bound;
    logic [7:0] prescale;
  } ewmon_cfg_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_FIRED = 2'b10
  } ewmon_state_type;

endpackage

// [verilog/ewmon_tick.sv]
// Purpose: prescaler turning low-power clock enables into counter ticks
// Assumes: i_lp_tick is a one-cycle pulse per low-power clock period
// Notes: divide ratio is prescale plus one
`timescale 1ns/1ps
module ewmon_tick
  import ewmon_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_run,
  input wire logic i_lp_tick,
  input wire logic [7:0] i_prescale,
  output logic o_tick
);

  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic next_tick;

  always_comb
  begin
    next_div_cnt = div_cnt;
    next_tick = 1'b0;
    if (!i_run)
    begin
      next_div_cnt = 8'h00;
    end
    else if (i_lp_tick)
    begin
      if (div_cnt >= i_prescale)
      begin
        next_div_cnt = 8'h00;
        next_tick = 1'b1;
      end
      else
      begin
        next_div_cnt = div_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      div_cnt <= 8'h00;
      o_tick <= 1'b0;
    end
    else if (i_ce)
    begin
      div_cnt <= next_div_cnt;
      o_tick <= next_tick;
    end
  end

endmodule // ewmon_tick

// [verilog/ewmon_top.sv]
// Purpose: external watchdog monitor with apb register access
// Assumes: i_srst is the processor reset; inputs synchronous to i_clk
// Notes: write-once settings lock individually after their first write;
//   the bus answers after one wait state
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module ewmon_top
  import ewmon_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_lp_tick,
  input wire logic i_ext_in,
  output logic o_monitor_out,
  output logic o_irq
);

  // ****************************************
  // state
  // ****************************************
  ewmon_cfg_type cfg;
  ewmon_cfg_type next_cfg;
  logic irq_enable_bit;
  logic next_irq_enable_bit;
  logic [NUM_SLOTS-1:0] written;
  logic [NUM_SLOTS-1:0] next_written;
  logic [7:0] count;
  logic [7:0] next_count;
  ewmon_state_type state;
  ewmon_state_type next_state;
  logic event_flag;
  logic next_event_flag;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic tick;
  // bus response marker
  logic resp_valid;
  logic next_resp_valid;

  logic wr_acc;
  logic rd_acc;
  logic acc_phase;
  logic first_acc;
  logic refresh_req;
  logic ext_asserted;
  logic running_flag;
  logic [NUM_SLOTS-1:0] slot_hit;

  function automatic logic [NUM_SLOTS-1:0] slot_decode(input logic [7:0] addr);
    logic [NUM_SLOTS-1:0] hit;
    hit = '0;
    if (addr == ADDR_CTRL)
    begin
      hit[SLOT_CTRL] = 1'b1;
    end
    else if (addr == ADDR_CMP_LOW)
    begin
      hit[SLOT_LOW] = 1'b1;
    end
    else if (addr == ADDR_CMP_HIGH)
    begin
      hit[SLOT_HIGH] = 1'b1;
    end
    else if (addr == ADDR_PRESCALE)
    begin
      hit[SLOT_PRE] = 1'b1;
    end
    return hit;
  endfunction

  // one wait state: read data and error are registered in the first access cycle,
  // so they already stand at the edge where the master samples pready high
  assign acc_phase = i_psel && i_penable;
  assign first_acc = i_ce && acc_phase && !resp_valid;
  assign o_pready = i_ce && acc_phase && resp_valid;
  assign wr_acc = o_pready && i_pwrite;
  assign rd_acc = first_acc && !i_pwrite;
  assign slot_hit = slot_decode(i_paddr);
  assign running_flag = cfg.enable;
  assign refresh_req = wr_acc && (i_paddr == ADDR_REFRESH) && (i_pwdata[7:0] == REFRESH_KEY);
  assign ext_asserted = cfg.input_enable && (i_ext_in == cfg.input_polarity_select);

  ewmon_tick u_tick (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_run(state == ST_RUN),
    .i_lp_tick(i_lp_tick),
    .i_prescale(cfg.prescale),
    .o_tick(tick)
  );

  // ****************************************
  // register writes
  // ****************************************
  always_comb
  begin
    // writes commit at the pready edge, which a low clock enable holds off
    next_cfg = cfg;
    next_irq_enable_bit = irq_enable_bit;
    next_written = written;
    next_pslverr = 1'b0;
    if (first_acc && i_pwrite)
    begin
      // decided a cycle early so it stands with pready; written cannot move before the commit
      next_pslverr = |(slot_hit & written);
    end
    if (wr_acc)
    begin
      // locking per register: a repeated ctrl write is refused with an error but still updates the irq enable bit
      if (|(slot_hit & written))
      begin
        if (slot_hit[SLOT_CTRL])
        begin
          next_irq_enable_bit = i_pwdata[CTRL_IRQ_BIT];
        end
      end
      else
      begin
        next_written = written | slot_hit;
        if (slot_hit[SLOT_CTRL])
        begin
          next_cfg.enable = i_pwdata[CTRL_EN_BIT];
          next_cfg.input_enable = i_pwdata[CTRL_INEN_BIT];
          next_cfg.input_polarity_select = i_pwdata[CTRL_POL_BIT];
          next_irq_enable_bit = i_pwdata[CTRL_IRQ_BIT];
        end
        else if (slot_hit[SLOT_LOW])
        begin
          next_cfg.window_low_bound = i_pwdata[7:0];
        end
        else if (slot_hit[SLOT_HIGH])
        begin
          next_cfg.window_high_bound = i_pwdata[7:0];
        end
        else if (slot_hit[SLOT_PRE])
        begin
          next_cfg.prescale = i_pwdata[7:0];
        end
      end
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_comb
  begin
    // set in the first access cycle, cleared again by the commit edge
    next_resp_valid = acc_phase && !resp_valid;
    next_prdata = o_prdata;
    if (rd_acc)
    begin
      next_prdata = 32'h0000_0000;
      if (i_paddr == ADDR_CTRL)
      begin
        next_prdata[CTRL_EN_BIT] = cfg.enable;
        next_prdata[CTRL_INEN_BIT] = cfg.input_enable;
        next_prdata[CTRL_POL_BIT] = cfg.input_polarity_select;
        next_prdata[CTRL_IRQ_BIT] = irq_enable_bit;
      end
      else if (i_paddr == ADDR_CMP_LOW)
      begin
        next_prdata[7:0] = cfg.window_low_bound;
      end
      else if (i_paddr == ADDR_CMP_HIGH)
      begin
        next_prdata[7:0] = cfg.window_high_bound;
      end
      else if (i_paddr == ADDR_PRESCALE)
      begin
        next_prdata[7:0] = cfg.prescale;
      end
      else if (i_paddr == ADDR_STATUS)
      begin
        next_prdata[STAT_RUN_BIT] = running_flag;
        next_prdata[STAT_EVT_BIT] = event_flag;
      end
      else if (i_paddr == ADDR_COUNT)
      begin
        next_prdata[7:0] = count;
      end
    end
  end

  // ****************************************
  // monitor engine
  // ****************************************
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_event_flag = event_flag;
    case (state)
      ST_IDLE:
      begin
        next_count = 8'h00;
        if (cfg.enable)
        begin
          next_state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (refresh_req)
        begin
          if (count >= cfg.window_low_bound && count <= cfg.window_high_bound)
          begin
            next_count = 8'h00;
          end
          else
          begin
            next_state = ST_FIRED;
            next_event_flag = 1'b1;
          end
        end
        else if (ext_asserted)
        begin
          next_state = ST_FIRED;
          next_event_flag = 1'b1;
        end
        else if (tick)
        begin
          // passing the high bound fires the monitor
          if (count >= cfg.window_high_bound)
          begin
            next_state = ST_FIRED;
            next_event_flag = 1'b1;
          end
          else
          begin
            next_count = count + 8'h01;
          end
        end
      end
      ST_FIRED:
      begin
        // only a processor reset leaves this state
        next_event_flag = 1'b1;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cfg <= '{enable: 1'b0, input_enable: 1'b0, input_polarity_select: 1'b0,
               window_low_bound: RST_CMP_LOW, window_high_bound: RST_CMP_HIGH, prescale: RST_PRESCALE};
      irq_enable_bit <= 1'b0;
      written <= '0;
      count <= 8'h00;
      state <= ST_IDLE;
      event_flag <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      resp_valid <= 1'b0;
      o_monitor_out <= 1'b0;
      o_irq <= 1'b0;
    end
    else if (i_ce)
    begin
      cfg <= next_cfg;
      irq_enable_bit <= next_irq_enable_bit;
      written <= next_written;
      count <= next_count;
      state <= next_state;
      event_flag <= next_event_flag;
      o_prdata <= next_prdata;
      o_pslverr <= next_pslverr;
      resp_valid <= next_resp_valid;
      o_monitor_out <= next_event_flag;
      o_irq <= next_event_flag && next_irq_enable_bit;
    end
  end

endmodule // ewmon_top

// [testbench/ewmon_top_sva.sv]
// Purpose: port checks for the watchdog monitor
// Assumes: prdata and pslverr stand while pready is high
// Notes: write-once history is rebuilt from bus traffic
`timescale 1ns/1ps
module ewmon_top_sva
  import ewmon_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_lp_tick,
  input wire logic i_ext_in,
  input wire logic o_monitor_out,
  input wire logic o_irq
);
  // ****************************************
  // write history
  // ****************************************
  logic wr;
  logic wo_hit;
  logic [1:0] slot;
  logic [3:0] seen;
  logic [3:0] next_seen;
  assign wr = i_ce && i_psel && i_penable && i_pwrite && o_pready;
  // slot index is the word offset of the first four registers
  assign wo_hit = wr && i_paddr <= ADDR_PRESCALE && i_paddr[1:0] == 2'b00;
  assign slot = i_paddr[3:2];
  always_comb
  begin
    next_seen = seen;
    if (wo_hit)
    begin
      next_seen[slot] = 1'b1;
    end
  end
  always_ff @(posedge i_clk)
  begin
    seen <= i_srst ? 4'h0 : next_seen;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_first_access;
    i_ce && i_psel && i_penable && !o_pready;
  endsequence
  sequence s_answer_once;
    o_pready ##1 !o_pready;
  endsequence
  a_ready_in_access: assert property (o_pready |-> i_ce && i_psel && i_penable)
    else $error("pready outside access");
  a_one_wait_state: assert property (s_first_access ##1 i_ce |-> s_answer_once)
    else $error("pready not after one wait");
  a_second_write_err: assert property (wo_hit && seen[slot] |-> o_pslverr)
    else $error("repeat write not refused");
  a_first_write_ok: assert property (wo_hit && !seen[slot] |-> !o_pslverr)
    else $error("first write refused");
  a_err_has_cause: assert property (o_pslverr |-> i_psel && i_penable && i_pwrite)
    else $error("stray error");
  a_read_no_err: assert property (o_pready && !i_pwrite |-> !o_pslverr)
    else $error("read refused");
  a_refresh_no_err: assert property (wr && i_paddr == ADDR_REFRESH |-> !o_pslverr)
    else $error("refresh refused");
  a_irq_needs_fire: assert property (o_irq |-> o_monitor_out) else $error("irq without event");
  a_fire_sticky: assert property (o_monitor_out |=> o_monitor_out) else $error("event dropped");
  a_reset_quiet: assert property ($fell(i_srst) |-> !o_monitor_out && !o_irq && !o_pslverr)
    else $error("outputs not cleared");
endmodule // ewmon_top_sva

bind ewmon_top ewmon_top_sva u_ewmon_top_sva (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_lp_tick(i_lp_tick), .i_ext_in(i_ext_in), .o_monitor_out(o_monitor_out), .o_irq(o_irq));

// [testbench/test_ewmon_top.sv]
// Purpose: self-checking bench for the watchdog monitor
// Assumes: apb slave answers after one wait state
// Notes: i_ce drops once to show the freeze
`timescale 1ns/1ps
module test_ewmon_top
  import ewmon_pkg::*;
;
  logic i_clk, i_srst, i_ce, i_psel, i_penable, i_pwrite, i_lp_tick, i_ext_in;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic o_pready, o_pslverr, o_monitor_out, o_irq, er;
  int fails;
  int check_count;
  ewmon_top u_ewmon_top (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_lp_tick(i_lp_tick),
    .i_ext_in(i_ext_in), .o_monitor_out(o_monitor_out), .o_irq(o_irq));
  // ****************************************
  // tasks
  // ****************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until pready is sampled high; data and error taken at that same edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1 && n < 20)
    begin
      @(posedge i_clk);
      n++;
    end
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    // an idle edge keeps the next setup out of this time step
    @(posedge i_clk);
    if (n >= 20)
    begin
      fails++;
      finish_test();
    end
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk({31'h0, er}, {31'h0, e});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_out(input logic m, input logic q);
    repeat (2) @(posedge i_clk);
    chk({30'h0, o_monitor_out, o_irq}, {30'h0, m, q});
  endtask
  task automatic do_reset();
    i_srst <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
  endtask
  task automatic lp_pulses(input int k);
    repeat (k)
    begin
      @(posedge i_clk);
      i_lp_tick <= 1'b1;
      @(posedge i_clk);
      i_lp_tick <= 1'b0;
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_defaults();
    rd_chk(ADDR_CMP_LOW, 32'(RST_CMP_LOW));
    rd_chk(ADDR_CMP_HIGH, 32'(RST_CMP_HIGH));
    rd_chk(ADDR_STATUS, 32'h0);
    rd_chk(8'h1C, 32'h0);
    wr_chk(8'h1C, 32'hFFFFFFFF, 1'b0);
  endtask
  task automatic t_lock();
    wr_chk(ADDR_CMP_LOW, 32'h02, 1'b0);
    wr_chk(ADDR_CMP_HIGH, 32'h08, 1'b0);
    wr_chk(ADDR_PRESCALE, 32'h00, 1'b0);
    wr_chk(ADDR_CTRL, 32'h09, 1'b0);
    rd_chk(ADDR_STATUS, 32'h1);
    wr_chk(ADDR_CMP_LOW, 32'h05, 1'b1);
    rd_chk(ADDR_CMP_LOW, 32'h02);
    wr_chk(ADDR_PRESCALE, 32'h03, 1'b1);
    wr_chk(ADDR_CTRL, 32'h01, 1'b1);
  endtask
  task automatic t_count();
    lp_pulses(4);
    rd_chk(ADDR_COUNT, 32'h4);
    wr_chk(ADDR_REFRESH, 32'(REFRESH_KEY), 1'b0);
    rd_chk(ADDR_COUNT, 32'h0);
    wait_out(1'b0, 1'b0);
  endtask
  // count 0 sits below the low bound, irq was switched off by the refused write
  task automatic t_fire();
    wr_chk(ADDR_REFRESH, 32'(REFRESH_KEY), 1'b0);
    wait_out(1'b1, 1'b0);
    wr_chk(ADDR_CTRL, 32'h08, 1'b1);
    wait_out(1'b1, 1'b1);
    rd_chk(ADDR_STATUS, 32'h3);
  endtask
  task automatic t_ext();
    do_reset();
    wr_chk(ADDR_CTRL, 32'h07, 1'b0);
    wait_out(1'b0, 1'b0);
    @(posedge i_clk);
    i_ext_in <= 1'b1;
    wait_out(1'b1, 1'b0);
  endtask
  // divide by two, polarity low with the pin idle high, frozen ticks, then overrun
  task automatic t_overrun();
    do_reset();
    wr_chk(ADDR_CMP_HIGH, 32'h03, 1'b0);
    wr_chk(ADDR_PRESCALE, 32'h01, 1'b0);
    wr_chk(ADDR_CTRL, 32'h0B, 1'b0);
    lp_pulses(6);
    rd_chk(ADDR_COUNT, 32'h3);
    i_ce <= 1'b0;
    lp_pulses(2);
    i_ce <= 1'b1;
    rd_chk(ADDR_COUNT, 32'h3);
    wait_out(1'b0, 1'b0);
    lp_pulses(2);
    wait_out(1'b1, 1'b1);
  endtask
  // pin idles high here, so pulling it low fires with polarity low
  task automatic t_ext_low();
    do_reset();
    wr_chk(ADDR_CTRL, 32'h03, 1'b0);
    wait_out(1'b0, 1'b0);
    @(posedge i_clk);
    i_ext_in <= 1'b0;
    wait_out(1'b1, 1'b0);
  endtask
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  initial
  begin
    {i_ce, i_psel, i_penable, i_pwrite, i_lp_tick, i_ext_in} = 6'b100000;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    fails = 0;
    check_count = 0;
    do_reset();
    t_defaults();
    t_lock();
    t_count();
    t_fire();
    t_ext();
    t_overrun();
    t_ext_low();
    finish_test();
  end
endmodule // test_ewmon_top
